// ---- src/pare_pkg.sv ----
// Package with register map, field layouts and reset values of the port A rise-edge block
package pare_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_RISE_EN   = 8'h00; // port_a_rise_enable
  localparam logic [7:0] OFF_FLAG      = 8'h04; // port_a_change_flag, write one to clear
  localparam logic [7:0] OFF_CTRL      = 8'h08; // change_irq_master_enable in bit 0
  localparam logic [7:0] OFF_SUMMARY   = 8'h0c; // change_summary_flag in bit 0, read only
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h10; // Mask of the same layout as the flag register
  // Implemented pin bits: 5, 4, 3, 1, 0
  localparam logic [7:0] PIN_MASK      = 8'h3b;
  // Reset values
  localparam logic [7:0] RISE_EN_RST   = 8'h00;
  localparam logic [7:0] FLAG_RST      = 8'h00;
  localparam logic [7:0] MASK_RST      = 8'h00;
  localparam logic       CTRL_EN_RST   = 1'b0;
  // Field position of the master enable and summary flag
  localparam int         CTRL_EN_BIT   = 0;
  localparam int         SUMMARY_BIT   = 0;
endpackage

// ---- src/pare_edge.sv ----
// Rising edge detector for a group of synchronous pins
`timescale 1ns/1ps
module pare_edge #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] enable,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] last_r; // Pin levels of the previous cycle

  initial begin
    if (WIDTH < 1) $error("pare_edge: WIDTH must be at least 1");
  end

  // Remember previous levels; reset to low so a pin high at release counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= '0;
    end else begin
      last_r <= pins;
    end
  end

  // Low then high on an enabled pin only
  assign rise = pins & ~last_r & enable;
endmodule

// ---- src/pare_top.sv ----
// Port A rising-edge enable with change flags, APB registers and interrupt
`timescale 1ns/1ps
module pare_top #(
  parameter int PINS = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  general_port_a,      // Pin levels, synchronous to pclk
  input  wire logic        port_b_flag_any,     // Any port B change flag set
  output logic             change_summary_flag, // OR of all change flags
  output logic             change_irq,          // Change interrupt request
  output logic             irq                  // Masked status interrupt
);
  // Storage registers
  logic [7:0]  rise_en_r;     // port_a_rise_enable
  logic [7:0]  flag_r;        // port_a_change_flag
  logic [7:0]  mask_r;        // Interrupt mask
  logic        master_en_r;   // change_irq_master_enable
  // Answer and output flops
  logic [31:0] prdata_r;      // Registered read data
  logic        pready_r;      // Registered ready
  logic        pslverr_r;     // Registered error
  logic        summary_r;     // Registered summary flag
  logic        change_irq_r;  // Registered change interrupt
  logic        irq_r;         // Registered masked interrupt
  // Combinational helpers
  logic [7:0]  rise;          // Enabled rising edges this cycle
  logic [7:0]  flag_nxt;      // Next flag value
  logic [7:0]  rise_en_nxt;   // Next enable value

  // The register layout is fixed at eight pins; refuse anything else early
  initial begin
    if (PINS != 8) $error("pare_top: PINS must be 8");
  end

  // Edge detector on the port pins
  // Its history flops run even with every enable off, so enabling never fakes an edge
  pare_edge #(.WIDTH(8)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (general_port_a),
    .enable  (rise_en_r),
    .rise    (rise)
  );

  // Bus decode: the first access cycle loads the answer flops, so pready
  // comes one cycle later; the write itself lands only on the completing
  // edge, where pready is high, as the bus protocol defines it
  wire acc      = psel & penable & ~pready_r; // First access cycle
  wire done     = psel & penable & pready_r;  // Completing access cycle
  wire wr       = done & pwrite;              // Write takes effect here
  wire hit_en   = (paddr == pare_pkg::OFF_RISE_EN);
  wire hit_flag = (paddr == pare_pkg::OFF_FLAG);
  wire hit_ctrl = (paddr == pare_pkg::OFF_CTRL);
  wire hit_sum  = (paddr == pare_pkg::OFF_SUMMARY);
  wire hit_mask = (paddr == pare_pkg::OFF_IRQ_MASK);
  wire hit_any  = hit_en | hit_flag | hit_ctrl | hit_sum | hit_mask;
  wire [7:0] wbyte = pwdata[7:0] & pare_pkg::PIN_MASK;
  wire [7:0] clr   = (wr & hit_flag) ? wbyte : 8'h00;

  // Flags: set beats write-one-to-clear, so a racing edge is never lost
  // A clear and an edge in one cycle leave the flag set for software
  assign flag_nxt    = (flag_r & ~clr) | (rise & pare_pkg::PIN_MASK);
  assign rise_en_nxt = (wr & hit_en) ? wbyte : rise_en_r;
  // Summary combines both ports; held as a flop for a clean output
  wire summary_nxt   = (|flag_nxt) | port_b_flag_any;

  // Read multiplexer; unimplemented bits come back zero
  // Control and summary hold one bit; the rest of the word reads zero
  wire [31:0] rd_mux =
      hit_en   ? {24'h000000, rise_en_r} :
      hit_flag ? {24'h000000, flag_r} :
      hit_ctrl ? {31'h00000000, master_en_r} :
      hit_sum  ? {31'h00000000, summary_r} :
      hit_mask ? {24'h000000, mask_r} : 32'h00000000;

  // Enable and flag storage; reset clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_en_r <= pare_pkg::RISE_EN_RST;
      flag_r    <= pare_pkg::FLAG_RST;
    end else begin
      rise_en_r <= rise_en_nxt;
      flag_r    <= flag_nxt;
    end
  end

  // Control and mask registers
  // Master enable only gates the request; detection never stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_en_r <= pare_pkg::CTRL_EN_RST;
      mask_r      <= pare_pkg::MASK_RST;
    end else begin
      if (wr & hit_ctrl) master_en_r <= pwdata[pare_pkg::CTRL_EN_BIT];
      if (wr & hit_mask) mask_r <= wbyte;
    end
  end

  // Bus answer: one wait state keeps every output on a flop
  // Read data are zero outside a read answer, so a stale value never leaks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc & ~hit_any;
      prdata_r  <= (acc & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Interrupt outputs follow the next-state flags so they line up with them
  // Using the next-state flags costs no cycle against the flags themselves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_r    <= 1'b0;
      change_irq_r <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      summary_r    <= summary_nxt;
      change_irq_r <= summary_nxt & master_en_r;
      irq_r        <= |(flag_nxt & mask_r);
    end
  end

  // Every output is a flop; the ports only rename them
  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign change_summary_flag = summary_r;
  assign change_irq          = change_irq_r;
  assign irq                 = irq_r;

  // Assertions: each guards one rule of the block's behaviour
  // An enabled edge on pin 3 shows up in its flag one edge later
  AST_EDGE_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (rise[3] |=> flag_r[3])) else $error("Enabled edge did not set flag");

  // A disabled pin never produces a rise, whatever its level does
  AST_DISABLED_NO_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (!rise_en_r[4] |-> !rise[4])) else $error("Disabled pin raised an edge");

  // Writes never reach the unimplemented enable bits
  AST_UNIMPL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    ((rise_en_r & ~pare_pkg::PIN_MASK) == 8'h00)) else $error("Unimplemented bit set");

  // Clear and edge together: the edge wins
  AST_RACE_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    ((rise[0] && wr && hit_flag) |=> flag_r[0])) else $error("Flag lost during clear");

  // Summary follows the flags at once and port B one flop behind
  AST_SUMMARY_OR: assert property (@(posedge pclk) disable iff (!presetn)
    (change_summary_flag == ((|flag_r) | $past(port_b_flag_any))))
    else $error("Summary flag not OR of flags");

  // Master enable off still flags but holds the request low
  AST_MASTER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    ((!master_en_r && rise[1]) |=> (flag_r[1] && !change_irq)))
    else $error("Master off handling wrong");

  // A write to the enable register stores only the implemented bits
  AST_EN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    ((wr && hit_en) |=> rise_en_r == ($past(pwdata[7:0]) & pare_pkg::PIN_MASK)))
    else $error("Enable write not stored");

  // A low-to-high pin on an enabled bit is seen in the same cycle
  AST_RISE_DETECT: assert property (@(posedge pclk) disable iff (!presetn)
    ((rise_en_r[5] && !$past(general_port_a[5]) && general_port_a[5]) |-> rise[5]))
    else $error("Rising edge missed");

  // Every access is answered exactly one cycle later, for one cycle
  AST_BUS_READY: assert property (@(posedge pclk) disable iff (!presetn)
    (acc |=> pready ##1 !pready)) else $error("Ready timing wrong");

  // Reset holds enables, flags, pready, summary and irq at their reset values
  AST_RESET_CLEARS: assert property (@(posedge pclk)
    (!presetn |=> (rise_en_r == pare_pkg::RISE_EN_RST && flag_r == pare_pkg::FLAG_RST
      && !pready && !change_summary_flag && !irq)))
    else $error("Reset did not clear the block");

  // Reads of a pin register show zeros outside the implemented bits
  AST_READ_PADS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    ((acc && !pwrite && (hit_en || hit_flag || hit_mask)) |=>
      ((prdata & ~{24'h000000, pare_pkg::PIN_MASK}) == 32'h00000000)))
    else $error("Unimplemented read bits not zero");

  // A flag never sets on its own, only on an enabled edge
  AST_FLAG_NEEDS_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ((!flag_r[4] && !rise[4]) |=> !flag_r[4])) else $error("Flag set with no edge");

  // Writing a one clears a flag when no edge races it
  AST_CLEAR_WORKS: assert property (@(posedge pclk) disable iff (!presetn)
    ((wr && hit_flag && pwdata[3] && !rise[3]) |=> !flag_r[3]))
    else $error("Flag not cleared by write");

  // An unmapped address answers with an error and zero data
  AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    ((acc && !hit_any) |=> (pslverr && prdata == 32'h00000000)))
    else $error("Unmapped access not refused");

  // A mapped address never answers with an error
  AST_MAPPED_OK: assert property (@(posedge pclk) disable iff (!presetn)
    ((acc && hit_any) |=> !pslverr)) else $error("Mapped access refused");

  // The change request can only stand while the summary does
  AST_IRQ_NEEDS_SUMMARY: assert property (@(posedge pclk) disable iff (!presetn)
    (change_irq |-> change_summary_flag)) else $error("Request without summary");
endmodule

// ---- tb/pare_pins.sv ----
// Model of the signals that drive the port A pins from outside
`timescale 1ns/1ps
module pare_pins (
  input  wire logic       pclk,           // System clock
  input  wire logic [7:0] want,           // Level the bench asks for
  output logic      [7:0] general_port_a  // Pin levels seen by the block
);
  // Pins change just after an edge so they always look synchronous;
  // pins 0 and 1 stay digital inputs, as if the serial bus were off
  always_ff @(posedge pclk) begin
    general_port_a <= want;
  end
endmodule

// ---- tb/pare_top_tb.sv ----
// Self-checking bench of the port A rise-edge block against a behavioural model
`timescale 1ns/1ps
module pare_top_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pb = 0;
  logic [7:0]  paddr = 8'h00, want = 8'h00, pins;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, summ, cirq, irq, er;
  // Model state: enables, flags, mask, previous pins, master enable
  int          err_total = 0, n_compared = 0, m_en = 0, m_fl = 0, m_mk = 0, m_pv = 0, m_ce = 0, v;
  always #2 pclk = ~pclk;
  pare_pins P (.pclk(pclk), .want(want), .general_port_a(pins));
  pare_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .general_port_a(pins), .port_b_flag_any(pb),
    .change_summary_flag(summ), .change_irq(cirq), .irq(irq));
  // One comparison, counted
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // APB transfer; pready is read before the edge's updates land
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // Move the pins, let the edge reach the flags, compare the outputs
  task automatic step(input logic [7:0] p, input logic b);
    want <= p;
    pb <= b;
    repeat (3) @(posedge pclk);
    m_fl |= p & ~m_pv & m_en;
    m_pv = p;
    chk("summary", (m_fl != 0) | b, summ);
    chk("change irq", ((m_fl != 0) | b) & m_ce, cirq);
    chk("irq", (m_fl & m_mk) != 0, irq);
  endtask
  initial begin
    v = $urandom(32'h943e);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rchk("reset value", 8'(i * 4), 0);
    apb(1'b0, 8'h14, 32'h0);
    chk("slave error", 1, er);
    // Enable register: all ones first, then random bytes
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hff : $urandom;
      apb(1'b1, pare_pkg::OFF_RISE_EN, v);
      m_en = v & 8'h3b;
      rchk("rise enable", pare_pkg::OFF_RISE_EN, m_en);
    end
    // Random pin traffic; master enable comes on halfway
    for (int i = 0; i < 16; i++) begin
      step(8'($urandom), 1'($urandom));
      rchk("flags", pare_pkg::OFF_FLAG, m_fl);
      rchk("summary reg", pare_pkg::OFF_SUMMARY, (m_fl != 0) | pb);
      if (i == 7) begin
        apb(1'b1, pare_pkg::OFF_CTRL, 32'h1);
        m_ce = 1;
        rchk("master enable", pare_pkg::OFF_CTRL, m_ce);
      end
      v = $urandom;
      apb(1'b1, pare_pkg::OFF_IRQ_MASK, v);
      m_mk = v & 8'h3b;
      rchk("irq mask", pare_pkg::OFF_IRQ_MASK, m_mk);
      apb(1'b1, pare_pkg::OFF_FLAG, v >> 8);
      m_fl &= ~(v >> 8);
      apb(1'b1, pare_pkg::OFF_RISE_EN, v >> 16);
      m_en = (v >> 16) & 8'h3b;
    end
    // An edge that lands on the clearing write's completing edge survives it
    apb(1'b1, pare_pkg::OFF_RISE_EN, 32'hff);
    m_en = 8'h3b;
    step(8'h00, 1'b0);
    fork
      apb(1'b1, pare_pkg::OFF_FLAG, 32'hff);
      begin
        repeat (2) @(posedge pclk);
        want <= 8'h3b;
      end
    join
    m_fl = 8'h3b;
    m_pv = 8'h3b;
    rchk("flags after race", pare_pkg::OFF_FLAG, m_fl);
    step(8'h3b, 1'b0);
    // Reset in mid-run: every register and output returns to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    m_en = 0;
    m_fl = 0;
    m_mk = 0;
    m_ce = 0;
    @(posedge pclk);
    chk("summary after reset", 0, summ);
    chk("change irq after reset", 0, cirq);
    chk("irq after reset", 0, irq);
    for (int i = 0; i < 5; i++) rchk("reset again", 8'(i * 4), 0);
    // Pins already high at release raise nothing until they fall and rise again
    apb(1'b1, pare_pkg::OFF_RISE_EN, 32'h20);
    m_en = 8'h20;
    step(8'h1b, 1'b0);
    step(8'h3b, 1'b0);
    rchk("flags after reset", pare_pkg::OFF_FLAG, m_fl);
    wrap_up();
  end
endmodule
